// [inc/dca_pkg.sv]
// package: register map, field positions, reset values and types of the converter control block
package dca_pkg;
	// ****************************************************************
	// geometry
	// ****************************************************************
	localparam int NUM_CH = 12;
	localparam int CODE_W = 12;
	localparam int NUM_IN = 4;
	localparam int NUM_TS = 3;
	localparam int NUM_STAT = 11;
	localparam int CNT_W = 9;
	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CFG0 = 8'h00;
	localparam logic [7:0] OFS_SYNCSEL = 8'h04;
	localparam logic [7:0] OFS_HWMASK0 = 8'h08;
	localparam logic [7:0] OFS_HWMASK1 = 8'h0c;
	localparam logic [7:0] OFS_SWCLR = 8'h10;
	localparam logic [7:0] OFS_EVTSEL = 8'h14;
	localparam logic [7:0] OFS_CHSEL = 8'h18;
	localparam logic [7:0] OFS_ALMCTL = 8'h1c;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_POWER = 8'h24;
	localparam logic [7:0] OFS_FILT = 8'h28;
	localparam logic [7:0] OFS_DATA = 8'h40;
	localparam logic [7:0] OFS_CLRSET = 8'h80;
	localparam logic [7:0] OFS_INTHR = 8'hc0;
	localparam logic [7:0] OFS_TSTHR = 8'hd0;
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CFG0_TRIG = 0;
	localparam int CFG0_GLOBAL_ALARM_FLAG = 1;
	localparam int EVT_INPUT = 0;
	localparam int EVT_TEMP = 1;
	localparam int EVT_OVERTEMP = 2;
	localparam int CHSEL_LSB = 3;
	localparam int ALM_LATCHDIS = 0;
	localparam int ALM_PINEN_LSB = 16;
	localparam int ST_TEMP_LSB = 4;
	localparam int ST_OVERTEMP = 10;
	localparam int PWR_LOCAL = 12;
	localparam int FILT_TEMP_LSB = 4;
	localparam int THR_HI_LSB = 16;
	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [CODE_W-1:0] RST_CODE = 12'h000;
	localparam logic [CODE_W-1:0] RST_THR_HI = 12'hfff;
	localparam logic [CODE_W-1:0] RST_THR_LO = 12'h000;
	localparam logic [2:0] RST_FILT_IN = 3'h3;
	localparam logic [1:0] RST_FILT_TS = 2'h2;
	localparam logic RST_LOCAL_ON = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} dca_axil_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dca_axil_rsp_t;
	typedef struct packed {
		logic valid;
		logic [1:0] index;
		logic [CODE_W-1:0] value;
	} dca_sample_t;
endpackage

// [verilog/dca_ctrl.sv]
// converter latch, clear and alarm control with an AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module dca_ctrl #(
	parameter int ADDR_W = 8
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire dca_pkg::dca_axil_req_t axiReq,
	output dca_pkg::dca_axil_rsp_t axiRsp,
	input wire logic clearPin0_n,
	input wire logic clearPin1_n,
	input wire logic overtempIn,
	input wire dca_pkg::dca_sample_t inSample,
	input wire dca_pkg::dca_sample_t tempSample,
	output logic [dca_pkg::NUM_CH-1:0][dca_pkg::CODE_W-1:0] converterOutput,
	output logic [dca_pkg::NUM_CH-1:0] outputEnable,
	output logic alarmPinO,
	output logic alarmPinOe
);
	// ****************************************************************
	// elaboration check
	// ****************************************************************
	if (ADDR_W != 8)
	begin : gBadAddr
		$error("dca_ctrl serves an 8-bit register address only");
	end

	localparam int NCH = dca_pkg::NUM_CH;
	localparam int CW = dca_pkg::CODE_W;
	localparam int NST = dca_pkg::NUM_STAT;
	localparam int TS0 = dca_pkg::ST_TEMP_LSB;

	// word decode shared by the data register and its latch
	function automatic logic hitWord(input logic [7:0] a, input logic [7:0] base, input int i);
		return a == base + 8'(4 * i);
	endfunction

	function automatic logic [dca_pkg::CNT_W-1:0] inCount(input logic [2:0] code);
		logic [dca_pkg::CNT_W-1:0] n;
		n = (code == 3'h0) ? 9'h001 : (9'h001 << ({1'b0, code} + 4'h1));
		return n;
	endfunction

	function automatic logic [dca_pkg::CNT_W-1:0] tsCount(input logic [1:0] code);
		logic [dca_pkg::CNT_W-1:0] n;
		n = 9'h001 << code;
		return n;
	endfunction

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [CW-1:0] dataReg_q [NCH];
	logic [CW-1:0] clrSet_q [NCH];
	logic [CW-1:0] inHi_q [dca_pkg::NUM_IN];
	logic [CW-1:0] inLo_q [dca_pkg::NUM_IN];
	logic [CW-1:0] tsHi_q [dca_pkg::NUM_TS];
	logic [CW-1:0] tsLo_q [dca_pkg::NUM_TS];
	logic [NCH-1:0] syncSel_q, hwMask0_q, hwMask1_q, swClr_q, chSel_q, pwrOut_q;
	logic [NCH-1:0] pending_q, cleared_q, clrNow;
	logic [2:0] evtSel_q;
	logic [2:0] filtIn_q;
	logic [1:0] filtTs_q;
	logic latchDis_q, localOn_q, trigPulse_q;
	logic [NST-1:0] pinEn_q, status_q, status_d, cond;
	logic [dca_pkg::CNT_W-1:0] cnt_q [NST];

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	logic awHeld_q, wHeld_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic wrEn, rdTake, statusRd;
	logic [7:0] wa;
	logic [31:0] rdVal;
	logic rdOk, wrOk;

	assign wrEn = awHeld_q & wHeld_q & ~axiRsp.bvalid;
	assign rdTake = axiReq.arvalid & axiRsp.arready;
	assign statusRd = rdTake & (axiReq.araddr == dca_pkg::OFS_STATUS);
	assign wa = awAddr_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			axiRsp <= '0;
		end
		else
		begin
			axiRsp.awready <= ~awHeld_q & ~(axiReq.awvalid & axiRsp.awready);
			axiRsp.wready <= ~wHeld_q & ~(axiReq.wvalid & axiRsp.wready);
			if (axiReq.awvalid & axiRsp.awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= axiReq.awaddr;
			end
			if (axiReq.wvalid & axiRsp.wready)
			begin
				wHeld_q <= 1'b1;
				wData_q <= axiReq.wdata;
				wStrb_q <= axiReq.wstrb;
			end
			if (wrEn)
			begin
				axiRsp.bvalid <= 1'b1;
				axiRsp.bresp <= wrOk ? dca_pkg::RESP_OKAY : dca_pkg::RESP_SLVERR;
			end
			else if (axiRsp.bvalid & axiReq.bready)
			begin
				axiRsp.bvalid <= 1'b0;
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				axiRsp.awready <= 1'b1;
				axiRsp.wready <= 1'b1;
			end
			axiRsp.arready <= ~axiRsp.rvalid & ~rdTake;
			if (rdTake)
			begin
				axiRsp.rvalid <= 1'b1;
				axiRsp.rdata <= rdVal;
				axiRsp.rresp <= rdOk ? dca_pkg::RESP_OKAY : dca_pkg::RESP_SLVERR;
			end
			else if (axiRsp.rvalid & axiReq.rready)
			begin
				axiRsp.rvalid <= 1'b0;
				axiRsp.arready <= 1'b1;
			end
		end
	end

	// write address decode: a legal word address inside any block of the map except the read-only status register
	always_comb
	begin
		wrOk = 1'b0;
		if (wa[1:0] == 2'h0)
		begin
			if (wa <= dca_pkg::OFS_FILT && wa != dca_pkg::OFS_STATUS)
			begin
				wrOk = 1'b1;
			end
			if (wa >= dca_pkg::OFS_DATA && wa < dca_pkg::OFS_DATA + 8'h30)
			begin
				wrOk = 1'b1;
			end
			if (wa >= dca_pkg::OFS_CLRSET && wa < dca_pkg::OFS_CLRSET + 8'h30)
			begin
				wrOk = 1'b1;
			end
			if (wa >= dca_pkg::OFS_INTHR && wa < dca_pkg::OFS_TSTHR + 8'h0c)
			begin
				wrOk = 1'b1;
			end
		end
	end

	// data registers read back the latch, not the data register
	always_comb
	begin
		logic [7:0] ra;
		logic [3:0] idx;
		ra = axiReq.araddr;
		idx = ra[5:2];
		rdVal = 32'h0000_0000;
		rdOk = (ra[1:0] == 2'h0);
		unique case (ra)
			dca_pkg::OFS_CFG0: rdVal[dca_pkg::CFG0_GLOBAL_ALARM_FLAG] = |status_q;
			dca_pkg::OFS_SYNCSEL: rdVal[NCH-1:0] = syncSel_q;
			dca_pkg::OFS_HWMASK0: rdVal[NCH-1:0] = hwMask0_q;
			dca_pkg::OFS_HWMASK1: rdVal[NCH-1:0] = hwMask1_q;
			dca_pkg::OFS_SWCLR: rdVal[NCH-1:0] = swClr_q;
			dca_pkg::OFS_EVTSEL: rdVal[2:0] = evtSel_q;
			dca_pkg::OFS_CHSEL: rdVal[dca_pkg::CHSEL_LSB +: NCH] = chSel_q;
			dca_pkg::OFS_ALMCTL:
			begin
				rdVal[dca_pkg::ALM_LATCHDIS] = latchDis_q;
				rdVal[dca_pkg::ALM_PINEN_LSB +: NST] = pinEn_q;
			end
			dca_pkg::OFS_STATUS: rdVal[NST-1:0] = status_q;
			dca_pkg::OFS_POWER:
			begin
				rdVal[NCH-1:0] = pwrOut_q;
				rdVal[dca_pkg::PWR_LOCAL] = localOn_q;
			end
			dca_pkg::OFS_FILT:
			begin
				rdVal[2:0] = filtIn_q;
				rdVal[dca_pkg::FILT_TEMP_LSB +: 2] = filtTs_q;
			end
			default:
			begin
				if (ra >= dca_pkg::OFS_DATA && ra < dca_pkg::OFS_DATA + 8'h30)
				begin
					rdVal[CW-1:0] = converterOutput[idx];
				end
				else if (ra >= dca_pkg::OFS_CLRSET && ra < dca_pkg::OFS_CLRSET + 8'h30)
				begin
					rdVal[CW-1:0] = clrSet_q[idx];
				end
				else if (ra >= dca_pkg::OFS_INTHR && ra < dca_pkg::OFS_TSTHR)
				begin
					rdVal[CW-1:0] = inLo_q[idx[1:0]];
					rdVal[dca_pkg::THR_HI_LSB +: CW] = inHi_q[idx[1:0]];
				end
				else if (ra >= dca_pkg::OFS_TSTHR && ra < dca_pkg::OFS_TSTHR + 8'h0c)
				begin
					rdVal[CW-1:0] = tsLo_q[idx[1:0]];
					rdVal[dca_pkg::THR_HI_LSB +: CW] = tsHi_q[idx[1:0]];
				end
				else
				begin
					rdOk = 1'b0;
				end
			end
		endcase
	end

	// ****************************************************************
	// control registers
	// ****************************************************************
	logic [31:0] wv, bm;
	assign bm = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
	assign wv = wData_q & bm;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncSel_q <= '0;
			hwMask0_q <= '0;
			hwMask1_q <= '0;
			swClr_q <= '0;
			chSel_q <= '0;
			evtSel_q <= 3'h0;
			latchDis_q <= 1'b0;
			pinEn_q <= '0;
			pwrOut_q <= '0;
			localOn_q <= dca_pkg::RST_LOCAL_ON;
			filtIn_q <= dca_pkg::RST_FILT_IN;
			filtTs_q <= dca_pkg::RST_FILT_TS;
			trigPulse_q <= 1'b0;
		end
		else
		begin
			trigPulse_q <= wrEn & (wa == dca_pkg::OFS_CFG0) & wv[dca_pkg::CFG0_TRIG];
			if (wrEn)
			begin
				unique case (wa)
					dca_pkg::OFS_SYNCSEL: syncSel_q <= (syncSel_q & ~bm[NCH-1:0]) | wv[NCH-1:0];
					dca_pkg::OFS_HWMASK0: hwMask0_q <= (hwMask0_q & ~bm[NCH-1:0]) | wv[NCH-1:0];
					dca_pkg::OFS_HWMASK1: hwMask1_q <= (hwMask1_q & ~bm[NCH-1:0]) | wv[NCH-1:0];
					dca_pkg::OFS_SWCLR: swClr_q <= (swClr_q & ~bm[NCH-1:0]) | wv[NCH-1:0];
					// event bits 2:0, channel bits 14:3
					dca_pkg::OFS_EVTSEL: evtSel_q <= (evtSel_q & ~bm[2:0]) | wv[2:0];
					dca_pkg::OFS_CHSEL: chSel_q <= (chSel_q & ~bm[dca_pkg::CHSEL_LSB +: NCH])
						| wv[dca_pkg::CHSEL_LSB +: NCH];
					dca_pkg::OFS_ALMCTL:
					begin
						latchDis_q <= bm[dca_pkg::ALM_LATCHDIS]
							? wv[dca_pkg::ALM_LATCHDIS] : latchDis_q;
						pinEn_q <= (pinEn_q & ~bm[dca_pkg::ALM_PINEN_LSB +: NST])
							| wv[dca_pkg::ALM_PINEN_LSB +: NST];
					end
					dca_pkg::OFS_POWER:
					begin
						pwrOut_q <= (pwrOut_q & ~bm[NCH-1:0]) | wv[NCH-1:0];
						localOn_q <= bm[dca_pkg::PWR_LOCAL]
							? wv[dca_pkg::PWR_LOCAL] : localOn_q;
					end
					dca_pkg::OFS_FILT:
					begin
						filtIn_q <= (filtIn_q & ~bm[2:0]) | wv[2:0];
						filtTs_q <= (filtTs_q & ~bm[dca_pkg::FILT_TEMP_LSB +: 2])
							| wv[dca_pkg::FILT_TEMP_LSB +: 2];
					end
					default:
					begin
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// data, clear-setting and threshold arrays
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				dataReg_q[i] <= dca_pkg::RST_CODE;
				clrSet_q[i] <= dca_pkg::RST_CODE;
			end
			for (int i = 0; i < dca_pkg::NUM_IN; i++)
			begin
				inHi_q[i] <= dca_pkg::RST_THR_HI;
				inLo_q[i] <= dca_pkg::RST_THR_LO;
			end
			for (int i = 0; i < dca_pkg::NUM_TS; i++)
			begin
				tsHi_q[i] <= dca_pkg::RST_THR_HI;
				tsLo_q[i] <= dca_pkg::RST_THR_LO;
			end
		end
		else if (wrEn)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (hitWord(wa, dca_pkg::OFS_DATA, i))
				begin
					dataReg_q[i] <= (dataReg_q[i] & ~bm[CW-1:0]) | wv[CW-1:0];
				end
				if (hitWord(wa, dca_pkg::OFS_CLRSET, i))
				begin
					clrSet_q[i] <= (clrSet_q[i] & ~bm[CW-1:0]) | wv[CW-1:0];
				end
			end
			for (int i = 0; i < dca_pkg::NUM_IN; i++)
			begin
				if (wa == dca_pkg::OFS_INTHR + 8'(4 * i))
				begin
					inLo_q[i] <= (inLo_q[i] & ~bm[CW-1:0]) | wv[CW-1:0];
					inHi_q[i] <= (inHi_q[i] & ~bm[dca_pkg::THR_HI_LSB +: CW])
						| wv[dca_pkg::THR_HI_LSB +: CW];
				end
			end
			for (int i = 0; i < dca_pkg::NUM_TS; i++)
			begin
				if (wa == dca_pkg::OFS_TSTHR + 8'(4 * i))
				begin
					tsLo_q[i] <= (tsLo_q[i] & ~bm[CW-1:0]) | wv[CW-1:0];
					tsHi_q[i] <= (tsHi_q[i] & ~bm[dca_pkg::THR_HI_LSB +: CW])
						| wv[dca_pkg::THR_HI_LSB +: CW];
				end
			end
		end
	end

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [2:0] pinMeta_q, pinSync_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pinMeta_q <= 3'h3;
			pinSync_q <= 3'h3;
		end
		else
		begin
			pinMeta_q <= {overtempIn, clearPin1_n, clearPin0_n};
			pinSync_q <= pinMeta_q;
		end
	end

	// ****************************************************************
	// clear state and latch
	// ****************************************************************
	logic autoEvt;
	always_comb
	begin
		autoEvt = (evtSel_q[dca_pkg::EVT_OVERTEMP] & status_q[dca_pkg::ST_OVERTEMP])
			| (evtSel_q[dca_pkg::EVT_INPUT] & (|status_q[dca_pkg::NUM_IN-1:0]))
			| (evtSel_q[dca_pkg::EVT_TEMP] & (|status_q[dca_pkg::ST_OVERTEMP-1:dca_pkg::ST_TEMP_LSB]));
		clrNow = (pinSync_q[0] ? '0 : hwMask0_q) | (pinSync_q[1] ? '0 : hwMask1_q)
			| swClr_q | (autoEvt ? chSel_q : '0);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			converterOutput <= '0;
			pending_q <= '0;
			cleared_q <= '0;
		end
		else
		begin
			cleared_q <= clrNow;
			for (int i = 0; i < NCH; i++)
			begin
				if (clrNow[i])
				begin
					converterOutput[i] <= clrSet_q[i];
				end
				else if (cleared_q[i])
				begin
					converterOutput[i] <= dataReg_q[i];
				end
				else if (!syncSel_q[i] && wrEn && hitWord(wa, dca_pkg::OFS_DATA, i))
				begin
					converterOutput[i] <= (dataReg_q[i] & ~bm[CW-1:0]) | wv[CW-1:0];
				end
				else if (trigPulse_q && syncSel_q[i] && pending_q[i])
				begin
					converterOutput[i] <= dataReg_q[i];
				end
				if (syncSel_q[i] && wrEn && hitWord(wa, dca_pkg::OFS_DATA, i))
				begin
					pending_q[i] <= 1'b1;
				end
				else if (trigPulse_q && syncSel_q[i])
				begin
					pending_q[i] <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// alarm filters and status
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int s = 0; s < NST; s++)
			begin
				cnt_q[s] <= '0;
			end
		end
		else
		begin
			for (int c = 0; c < dca_pkg::NUM_IN; c++)
			begin
				if (inSample.valid && inSample.index == 2'(c))
				begin
					if (inSample.value > inHi_q[c] || inSample.value < inLo_q[c]
						|| inHi_q[c] < inLo_q[c])
					begin
						cnt_q[c] <= (cnt_q[c] >= inCount(filtIn_q)) ? cnt_q[c] : cnt_q[c] + 9'h001;
					end
					else
					begin
						cnt_q[c] <= '0;
					end
				end
			end
			for (int t = 0; t < dca_pkg::NUM_TS; t++)
			begin
				if (tempSample.valid && tempSample.index == 2'(t))
				begin
					for (int k = 0; k < 2; k++)
					begin
						if ((k == 0) ? (tempSample.value > tsHi_q[t])
							: (tempSample.value < tsLo_q[t]))
						begin
							cnt_q[TS0 + 2 * t + k] <= (cnt_q[TS0 + 2 * t + k]
								>= tsCount(filtTs_q)) ? cnt_q[TS0 + 2 * t + k]
								: cnt_q[TS0 + 2 * t + k] + 9'h001;
						end
						else
						begin
							cnt_q[TS0 + 2 * t + k] <= '0;
						end
					end
				end
			end
		end
	end

	always_comb
	begin
		for (int c = 0; c < dca_pkg::NUM_IN; c++)
		begin
			cond[c] = cnt_q[c] >= inCount(filtIn_q);
		end
		for (int u = dca_pkg::ST_TEMP_LSB; u < dca_pkg::ST_OVERTEMP; u++)
		begin
			cond[u] = cnt_q[u] >= tsCount(filtTs_q);
		end
		cond[dca_pkg::ST_OVERTEMP] = pinSync_q[2] & localOn_q;
		status_d = latchDis_q ? cond : (cond | (status_q & {NST{~statusRd}}));
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_q <= '0;
			alarmPinO <= 1'b0;
			alarmPinOe <= 1'b0;
			outputEnable <= '0;
		end
		else
		begin
			status_q <= status_d;
			alarmPinO <= 1'b0;
			alarmPinOe <= |(status_d & pinEn_q);
			outputEnable <= pwrOut_q;
		end
	end
endmodule

// [dv/dca_ctrl_assertions.sv]
// checker for the converter control block ports
`timescale 1ns/100ps
module dca_ctrl_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire dca_pkg::dca_axil_req_t axiReq,
	input wire dca_pkg::dca_axil_rsp_t axiRsp,
	input wire logic [dca_pkg::NUM_CH-1:0][dca_pkg::CODE_W-1:0] converterOutput,
	input wire logic [dca_pkg::NUM_CH-1:0] outputEnable,
	input wire logic alarmPinO,
	input wire logic alarmPinOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ****************************************************************
	// reset and output checks
	// ****************************************************************
	AST_RST_CODE: assert property ($rose(rst_n) |-> converterOutput == '0)
		else $error("latch code not zero after reset");
	AST_RST_OFF: assert property ($rose(rst_n) |-> outputEnable == '0)
		else $error("output buffer on after reset");
	// enables only move one cycle after a completed write
	AST_OE_WR: assert property ($changed(outputEnable) |-> $past(axiRsp.bvalid))
		else $error("output enable changed without a write");
	// open drain: the pin is only ever pulled low
	AST_PIN_LOW: assert property (alarmPinO == 1'b0)
		else $error("alarm pin drives high");
	// the pin sampled at a flag read and the flag it returns come from one status word
	AST_PIN_GLOBAL_ALARM_FLAG: assert property (alarmPinOe && axiReq.arvalid && axiRsp.arready
		&& axiReq.araddr == dca_pkg::OFS_CFG0 |=> axiRsp.rdata[dca_pkg::CFG0_GLOBAL_ALARM_FLAG])
		else $error("alarm pin active with global flag clear");
	// ****************************************************************
	// register bus checks
	// ****************************************************************
	AST_B_AFTER: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
		&& axiRsp.wready |-> ##2 axiRsp.bvalid)
		else $error("write response late");
	AST_B_REFUSE: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
		else $error("new write accepted during response");
	AST_B_DONE: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid
		&& axiRsp.awready)
		else $error("write response not retired");
	AST_R_AFTER: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid
		&& !axiRsp.arready)
		else $error("read data late");
	AST_R_DONE: assert property (axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid)
		else $error("read data not retired");
endmodule
bind dca_ctrl dca_ctrl_chk u_chk (.clk(clk), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
	.converterOutput(converterOutput), .outputEnable(outputEnable), .alarmPinO(alarmPinO),
	.alarmPinOe(alarmPinOe));

// [dv/tb_dca_update_clear_alarm.sv]
// self-checking bench for the converter control block
`timescale 1ns/100ps
module tb_dca_update_clear_alarm;
	logic clk, rst_n, clr0_n, clr1_n, otIn, pinO, pinOe;
	dca_pkg::dca_axil_req_t req;
	dca_pkg::dca_axil_rsp_t rsp;
	dca_pkg::dca_sample_t iSmp, tSmp;
	logic [dca_pkg::NUM_CH-1:0][dca_pkg::CODE_W-1:0] dout;
	logic [dca_pkg::NUM_CH-1:0] oe;
	logic [1:0] lastResp;
	int fails, nChecks;
	dca_ctrl dut (.clk(clk), .rst_n(rst_n), .axiReq(req), .axiRsp(rsp),
		.clearPin0_n(clr0_n), .clearPin1_n(clr1_n), .overtempIn(otIn), .inSample(iSmp),
		.tempSample(tSmp), .converterOutput(dout), .outputEnable(oe), .alarmPinO(pinO),
		.alarmPinOe(pinOe));
	always #2 clk = ~clk;
	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
		nChecks++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [31:0] co(input int n);
		return 32'(dout[n]);
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, b;
		@(posedge clk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge clk);
			ta = rsp.awready;
			tw = rsp.wready;
			b = rsp.bvalid;
			lastResp = rsp.bresp;
			@(posedge clk);
			if (ta) req.awvalid <= 1'b0;
			if (tw) req.wvalid <= 1'b0;
		end
		req.bready <= 1'b0;
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic ta, r;
		logic [31:0] d;
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		r = 1'b0;
		while (!r)
		begin
			@(negedge clk);
			ta = rsp.arready;
			r = rsp.rvalid;
			d = rsp.rdata;
			lastResp = rsp.rresp;
			@(posedge clk);
			if (ta) req.arvalid <= 1'b0;
		end
		req.rready <= 1'b0;
		chk(nm, d, e);
	endtask
	// one conversion result, then time for count, status and pin to settle
	task automatic smp(input logic t, input logic [1:0] i, input logic [11:0] v);
		@(posedge clk);
		if (t) tSmp <= '{1'b1, i, v};
		else iSmp <= '{1'b1, i, v};
		@(posedge clk);
		tSmp.valid <= 1'b0;
		iSmp.valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", nChecks, fails);
		if (fails == 0 && nChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		results();
	end
	// ****************************************************************
	// tests
	// ****************************************************************
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		req = '0;
		clr0_n = 1'b1;
		clr1_n = 1'b1;
		otIn = 1'b0;
		iSmp = '0;
		tSmp = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		chk("code0", co(0), 32'h0);
		chk("oe", 32'(oe), 32'h0);
		rc("data5", 8'h54, 32'h0);
		wr(8'h24, 32'h0000_1fff);
		repeat (2) @(posedge clk);
		chk("oeOn", 32'(oe), 32'h0000_0fff);
		wr(8'h40, 32'h0000_0123);
		chk("async", co(0), 32'h0000_0123);
		rc("readLatch", 8'h40, 32'h0000_0123);
		wr(8'h04, 32'h0000_0006);
		wr(8'h44, 32'h0000_00a5);
		wr(8'h48, 32'h0000_005a);
		chk("syncHold", co(1), 32'h0);
		wr(8'h00, 32'h0000_0001);
		repeat (3) @(posedge clk);
		chk("trig1", co(1), 32'h0000_00a5);
		chk("trig2", co(2), 32'h0000_005a);
		rc("trigRead", 8'h00, 32'h0);
		wr(8'h80, 32'h0000_0fff);
		wr(8'h08, 32'h0000_0001);
		clr0_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk("pinClr", co(0), 32'h0000_0fff);
		chk("unmasked", co(1), 32'h0000_00a5);
		rc("dataKept", 8'h40, 32'h0000_0fff);
		clr0_n <= 1'b1;
		repeat (5) @(posedge clk);
		chk("pinExit", co(0), 32'h0000_0123);
		wr(8'h10, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk("swClr", co(0), 32'h0000_0fff);
		wr(8'h10, 32'h0);
		repeat (2) @(posedge clk);
		chk("swExit", co(0), 32'h0000_0123);
		wr(8'h28, 32'h0);
		wr(8'hc0, 32'h0100_0010);
		wr(8'h1c, 32'h0001_0000);
		smp(1'b0, 2'h0, 12'h200);
		chk("pinOn", 32'(pinOe), 32'h1);
		rc("global", 8'h00, 32'h0000_0002);
		smp(1'b0, 2'h0, 12'h080);
		rc("latched", 8'h20, 32'h0000_0001);
		rc("readClr", 8'h20, 32'h0);
		chk("pinOff", 32'(pinOe), 32'h0);
		smp(1'b0, 2'h0, 12'h008);
		smp(1'b0, 2'h0, 12'h080);
		rc("belowLow", 8'h20, 32'h0000_0001);
		wr(8'hd4, 32'h0100_0010);
		smp(1'b1, 2'h1, 12'h200);
		chk("masked", 32'(pinOe), 32'h0);
		smp(1'b1, 2'h1, 12'h080);
		rc("upper", 8'h20, 32'h0000_0040);
		smp(1'b1, 2'h1, 12'h008);
		smp(1'b1, 2'h1, 12'h080);
		rc("lower", 8'h20, 32'h0000_0080);
		wr(8'h1c, 32'h0001_0001);
		wr(8'h14, 32'h0000_0001);
		wr(8'h18, 32'h0000_0008);
		smp(1'b0, 2'h0, 12'h200);
		chk("autoClr", co(0), 32'h0000_0fff);
		smp(1'b0, 2'h0, 12'h080);
		chk("unlatched", 32'(pinOe), 32'h0);
		chk("autoExit", co(0), 32'h0000_0123);
		// channel 1 clear code is still its reset value
		wr(8'h14, 32'h0000_0004);
		wr(8'h18, 32'h0000_0010);
		otIn <= 1'b1;
		repeat (5) @(posedge clk);
		chk("otClr", co(1), 32'h0);
		rc("otFlag", 8'h20, 32'h0000_0400);
		otIn <= 1'b0;
		repeat (5) @(posedge clk);
		wr(8'h24, 32'h0000_0fff);
		otIn <= 1'b1;
		repeat (5) @(posedge clk);
		chk("otOff", co(1), 32'h0000_00a5);
		otIn <= 1'b0;
		wr(8'hc4, 32'h0010_0100);
		smp(1'b0, 2'h1, 12'h080);
		rc("inverted", 8'h20, 32'h0000_0002);
		// input filter of four: three results out of range leave the bit clear
		wr(8'h28, 32'h0000_0001);
		repeat (3) smp(1'b0, 2'h0, 12'h200);
		rc("filt3", 8'h20, 32'h0);
		smp(1'b0, 2'h0, 12'h200);
		rc("filt4", 8'h20, 32'h0000_0001);
		rc("unmapped", 8'h30, 32'h0);
		chk("rresp", 32'(lastResp), 32'h2);
		wr(8'h20, 32'h0);
		chk("bresp", 32'(lastResp), 32'h2);
		results();
	end
endmodule
